// file: hw/rcwl_pkg.sv
package rcwl_pkg;

  // Word layout, bit 0 is the most significant bit of the word
  localparam int WORD_W          = 32;
  localparam int BYTE_W          = 8;
  localparam int BYTES_PER_WORD  = 4;
  localparam int HALF_W          = 16;
  localparam int BOOT_ADDR_W     = 8;

  // Field positions, counted with bit 0 as the word's msb
  localparam int POS_ARB         = 0;
  localparam int POS_MEMCTL      = 1;
  localparam int POS_L7INT       = 2;
  localparam int POS_BUSMODE     = 3;
  localparam int POS_BPW         = 4;
  localparam int POS_ISPW        = 7;
  localparam int POS_INTERRUPT_PIN_CONFIG        = 8;
  localparam int POS_PARITY_PIN_CONFIG        = 10;
  localparam int POS_NMI         = 12;
  localparam int POS_ISB         = 13;
  localparam int POS_BBD         = 17;
  localparam int POS_TRANSFER_CODE_PIN_CONFIG        = 22;
  localparam int POS_DLL         = 27;
  localparam int POS_MODCK       = 28;

  // Internal default word, bit 0 first (bytes 2c 00 02 1e)
  localparam logic [31:0] DEFAULT_WORD = 32'h2c00021e;

  // Boot memory byte addresses 0, 8, 0x18, 0x20
  localparam logic [7:0] BOOT_ADDR0 = 8'h00;
  localparam logic [7:0] BOOT_ADDR1 = 8'h08;
  localparam logic [7:0] BOOT_ADDR2 = 8'h18;
  localparam logic [7:0] BOOT_ADDR3 = 8'h20;

  // Reset timing
  localparam int          CLK_MHZ          = 40;
  localparam int          RESET_STRETCH_CY = 512;
  localparam int          SOFT_TAIL_CY     = 3;
  localparam logic [9:0]  STRETCH_LOAD     = 10'(RESET_STRETCH_CY - 1);
  localparam logic [1:0]  TAIL_LOAD        = 2'(SOFT_TAIL_CY - 1);

  // Boot source encodings
  localparam logic [1:0] BOOT_EXT_MEM = 2'h0;
  localparam logic [1:0] BOOT_HOST    = 2'h1;
  localparam logic [1:0] BOOT_EEPROM  = 2'h2;
  localparam logic [1:0] BOOT_RSVD    = 2'h3;

  typedef enum logic [1:0] {
    RCWL_SRC_DEFAULT,
    RCWL_SRC_MEMORY,
    RCWL_SRC_HOST
  } rcwl_src_t;

  typedef struct packed {
    logic       external_arbitration_select;
    logic       external_memctl_select;
    logic       line_seven_int_out_select;
    logic       bus_mode_select;
    logic [1:0] boot_port_width;
    logic       boot_port_32;
    logic       internal_space_port_width;
    logic       isp_64;
    logic [1:0] interrupt_pin_config;
    logic       irq_pins_nc;
    logic [1:0] parity_pin_config;
    logic       parity_as_irq;
    logic       nmi_route_select;
    logic       nmi_to_core;
    logic [2:0] internal_space_base;
    logic [31:0] internal_space_addr;
    logic       bus_busy_pin_select;
    logic [1:0] transfer_code_pin_config;
    logic       tc_as_bank_select;
    logic       delay_loop_disable;
    logic [2:0] clock_mode_high_bits;
  } rcwl_fields_t;

  typedef struct packed {
    logic       debug_enable;
    logic [1:0] boot_source;
    logic       host_port_on;
  } rcwl_straps_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic        read;
  } rcwl_mem_req_t;

  // Bit n of the word as numbered with bit 0 the msb
  function automatic logic wbit(input logic [31:0] w, input int n);
    return w[WORD_W - 1 - n];
  endfunction

endpackage

// file: hw/rcwl_loader.sv
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module rcwl_loader
  import rcwl_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk_in,
  input  wire logic                 nrst_in,
  // Reset pins
  input  wire logic                 power_on_reset_n_in,
  input  wire logic                 hard_reset_n_in,
  input  wire logic                 reset_config_select_in,
  // Strap pins
  input  wire logic                 host_port_enable_pin_in,
  input  wire logic                 debug_select_pin_in,
  input  wire logic [1:0]           boot_mode_pins_in,
  // Internal reset sources
  input  wire logic                 int_hard_src_in,
  input  wire logic                 int_soft_src_in,
  // Boot memory
  output var  rcwl_pkg::rcwl_mem_req_t mem_req_out,
  input  wire logic [7:0]           mem_data_in,
  // Host write port, same clock
  input  wire logic                 host_wr_in,
  input  wire logic                 host_half_sel_in,
  input  wire logic [15:0]          host_data_in,
  // Results
  output logic [31:0]               hard_config_word_out,
  output var  rcwl_pkg::rcwl_fields_t fields_out,
  output var  rcwl_pkg::rcwl_straps_t straps_out,
  output logic                      config_done_out,
  output logic                      hard_reset_n_out,
  output logic                      hard_reset_n_oe_out,
  output logic                      soft_reset_n_out,
  output logic                      soft_reset_n_oe_out
);
  import rcwl_pkg::*;

  typedef enum logic [2:0] {
    RCWL_IDLE,
    RCWL_ADDR,
    RCWL_CAPT,
    RCWL_HOST,
    RCWL_DONE
  } rcwl_state_t;

  // Pin synchronisers, two stages each
  logic [5:0] s1_reg, s2_reg;
  logic [1:0] bm1_reg, bm2_reg;
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      s1_reg  <= 6'h3f;
      s2_reg  <= 6'h3f;
      bm1_reg <= 2'h0;
      bm2_reg <= 2'h0;
    end else begin
      s1_reg  <= {power_on_reset_n_in, hard_reset_n_in, reset_config_select_in,
                  host_port_enable_pin_in, debug_select_pin_in, 1'b1};
      s2_reg  <= s1_reg;
      bm1_reg <= boot_mode_pins_in;
      bm2_reg <= bm1_reg;
    end
  end
  logic por_n_s, hrst_n_s, rcs_s, hpe_s, dbg_s;
  always_comb begin
    por_n_s  = s2_reg[5];
    hrst_n_s = s2_reg[4];
    rcs_s    = s2_reg[3];
    hpe_s    = s2_reg[2];
    dbg_s    = s2_reg[1];
  end

  // State
  rcwl_state_t  st_reg, st_next;
  logic [31:0]  word_reg, word_next;
  logic [1:0]   idx_reg, idx_next;
  logic         hpe_reg, hpe_next;
  logic         por_d_reg, por_d_next;
  logic         first_reg, first_next;
  logic         dll_reg, dll_next;
  logic         dbg_reg, dbg_next;
  logic [1:0]   bm_reg, bm_next;
  logic         hrst_d_reg, hrst_d_next;
  logic [1:0]   half_reg, half_next;
  logic         done_reg, done_next;
  rcwl_mem_req_t req_reg, req_next;
  logic [9:0]   hcnt_reg, hcnt_next;
  logic [9:0]   scnt_reg, scnt_next;
  logic [1:0]   tail_reg, tail_next;
  logic         hdrv_reg, hdrv_next;
  logic         sdrv_reg, sdrv_next;
  logic         hwas_reg, hwas_next;

  function automatic logic [7:0] boot_addr(input logic [1:0] i);
    case (i)
      2'h0:    return BOOT_ADDR0;
      2'h1:    return BOOT_ADDR1;
      2'h2:    return BOOT_ADDR2;
      default: return BOOT_ADDR3;
    endcase
  endfunction

  logic hrst_fall, por_rise, hard_any;

  always_comb begin
    st_next     = st_reg;
    word_next   = word_reg;
    idx_next    = idx_reg;
    hpe_next    = hpe_reg;
    por_d_next  = por_n_s;
    first_next  = first_reg;
    dll_next    = dll_reg;
    dbg_next    = dbg_reg;
    bm_next     = bm_reg;
    half_next   = half_reg;
    done_next   = done_reg;
    req_next    = '0;
    hard_any    = !hrst_n_s || hdrv_reg;
    hrst_d_next = hard_any;
    hrst_fall   = hard_any && !hrst_d_reg;
    por_rise    = por_n_s && !por_d_reg;
    // Straps caught on power-on release
    if (por_rise) begin
      hpe_next   = hpe_s;
      dbg_next   = !dbg_s;
      bm_next    = bm2_reg;
      first_next = 1'b1;
    end
    if (!por_n_s) begin
      st_next   = RCWL_IDLE;
      done_next = 1'b0;
    end else if (hrst_fall) begin
      done_next = 1'b0;
      idx_next  = 2'h0;
      half_next = 2'h0;
      if (!rcs_s) begin
        st_next   = RCWL_DONE;
        word_next = DEFAULT_WORD;
      end else if (hpe_reg) begin
        st_next = RCWL_HOST;
      end else begin
        st_next = RCWL_ADDR;
      end
    end else begin
      case (st_reg)
        RCWL_IDLE: begin
          st_next = RCWL_IDLE;
        end
        RCWL_ADDR: begin
          req_next.addr = boot_addr(idx_reg);
          req_next.read = 1'b1;
          st_next       = RCWL_CAPT;
        end
        RCWL_CAPT: begin
          // Byte lands msb first, bit 0 of the word is the msb
          word_next = {word_reg[23:0], mem_data_in};
          idx_next  = idx_reg + 2'h1;
          st_next   = (idx_reg == 2'(BYTES_PER_WORD - 1)) ? RCWL_DONE : RCWL_ADDR;
        end
        RCWL_HOST: begin
          if (host_wr_in) begin
            if (host_half_sel_in) begin
              word_next[15:0] = host_data_in;
              half_next[1]    = 1'b1;
            end else begin
              word_next[31:16] = host_data_in;
              half_next[0]     = 1'b1;
            end
          end
          if (&half_reg) begin
            st_next = RCWL_DONE;
          end
        end
        RCWL_DONE: begin
          if (!done_reg) begin
            done_next = 1'b1;
            // Only the first load after power-up may change the loop setting
            if (first_reg) begin
              dll_next   = wbit(word_reg, POS_DLL);
              first_next = 1'b0;
            end
          end
        end
        default: st_next = RCWL_IDLE;
      endcase
    end
  end

  // Reset stretch and sequencing
  always_comb begin
    hcnt_next = hcnt_reg;
    scnt_next = scnt_reg;
    tail_next = tail_reg;
    hdrv_next = hdrv_reg;
    sdrv_next = sdrv_reg;
    hwas_next = hard_any;
    if (int_hard_src_in && !hdrv_reg) begin
      hdrv_next = 1'b1;
      hcnt_next = STRETCH_LOAD;
    end else if (hdrv_reg) begin
      if (hcnt_reg == 10'h0) begin
        hdrv_next = 1'b0;
      end else begin
        hcnt_next = hcnt_reg - 10'h1;
      end
    end
    if (int_soft_src_in && !sdrv_reg) begin
      sdrv_next = 1'b1;
      scnt_next = STRETCH_LOAD;
      tail_next = 2'h0;
    end else if (hard_any) begin
      sdrv_next = 1'b1;
      scnt_next = 10'h0;
      tail_next = TAIL_LOAD;
    end else if (hwas_reg) begin
      // First quiet cycle already counts toward the three-clock tail
      tail_next = TAIL_LOAD - 2'h1;
    end else if (sdrv_reg) begin
      if (tail_reg != 2'h0) begin
        tail_next = tail_reg - 2'h1;
      end else if (scnt_reg != 10'h0) begin
        scnt_next = scnt_reg - 10'h1;
      end else begin
        sdrv_next = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      st_reg     <= RCWL_IDLE;
      word_reg   <= DEFAULT_WORD;
      idx_reg    <= 2'h0;
      hpe_reg    <= 1'b0;
      por_d_reg  <= 1'b1; // Matches synced reset level, no false power-on edge
      first_reg  <= 1'b1;
      dll_reg    <= 1'b0;
      dbg_reg    <= 1'b0;
      bm_reg     <= BOOT_EXT_MEM;
      hrst_d_reg <= 1'b0;
      half_reg   <= 2'h0;
      done_reg   <= 1'b0;
      req_reg    <= '0;
      hcnt_reg   <= 10'h0;
      scnt_reg   <= 10'h0;
      tail_reg   <= 2'h0;
      hdrv_reg   <= 1'b0;
      sdrv_reg   <= 1'b0;
      hwas_reg   <= 1'b0;
    end else begin
      st_reg     <= st_next;
      word_reg   <= word_next;
      idx_reg    <= idx_next;
      hpe_reg    <= hpe_next;
      por_d_reg  <= por_d_next;
      first_reg  <= first_next;
      dll_reg    <= dll_next;
      dbg_reg    <= dbg_next;
      bm_reg     <= bm_next;
      hrst_d_reg <= hrst_d_next;
      half_reg   <= half_next;
      done_reg   <= done_next;
      req_reg    <= req_next;
      hcnt_reg   <= hcnt_next;
      scnt_reg   <= scnt_next;
      tail_reg   <= tail_next;
      hdrv_reg   <= hdrv_next;
      sdrv_reg   <= sdrv_next;
      hwas_reg   <= hwas_next;
    end
  end

  // Field decode of the committed word
  rcwl_fields_t f;
  always_comb begin
    f = '0;
    f.external_arbitration_select = wbit(word_reg, POS_ARB);
    f.external_memctl_select      = wbit(word_reg, POS_MEMCTL);
    f.line_seven_int_out_select   = wbit(word_reg, POS_L7INT);
    f.bus_mode_select             = wbit(word_reg, POS_BUSMODE);
    f.boot_port_width = {wbit(word_reg, POS_BPW), wbit(word_reg, POS_BPW + 1)};
    f.boot_port_32    = &f.boot_port_width;
    f.internal_space_port_width = wbit(word_reg, POS_ISPW);
    f.isp_64          = !f.internal_space_port_width;
    f.interrupt_pin_config = {wbit(word_reg, POS_INTERRUPT_PIN_CONFIG), wbit(word_reg, POS_INTERRUPT_PIN_CONFIG + 1)};
    f.irq_pins_nc     = (f.interrupt_pin_config == 2'h0);
    f.parity_pin_config = {wbit(word_reg, POS_PARITY_PIN_CONFIG), wbit(word_reg, POS_PARITY_PIN_CONFIG + 1)};
    f.parity_as_irq   = (f.parity_pin_config == 2'h0);
    f.nmi_route_select = wbit(word_reg, POS_NMI);
    f.nmi_to_core     = !f.nmi_route_select;
    f.internal_space_base = {wbit(word_reg, POS_ISB), wbit(word_reg, POS_ISB + 1),
                             wbit(word_reg, POS_ISB + 2)};
    // Base 000 maps to 0xf0000000; each step moves down 32 MB in this model
    f.internal_space_addr = 32'hf0000000 - {4'h0, f.internal_space_base, 25'h0};
    f.bus_busy_pin_select = wbit(word_reg, POS_BBD);
    f.transfer_code_pin_config = {wbit(word_reg, POS_TRANSFER_CODE_PIN_CONFIG), wbit(word_reg, POS_TRANSFER_CODE_PIN_CONFIG + 1)};
    f.tc_as_bank_select = (f.transfer_code_pin_config == 2'h2);
    f.delay_loop_disable = dll_reg;
    f.clock_mode_high_bits = {wbit(word_reg, POS_MODCK), wbit(word_reg, POS_MODCK + 1),
                              wbit(word_reg, POS_MODCK + 2)};
  end

  rcwl_straps_t sp;
  always_comb begin
    sp.debug_enable = dbg_reg;
    sp.boot_source  = bm_reg;
    sp.host_port_on = hpe_reg;
  end

  // Outputs registered
  logic [31:0]   word_o_reg;
  rcwl_fields_t  f_reg;
  rcwl_straps_t  sp_reg;
  logic          done_o_reg, h_o_reg, s_o_reg;
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      word_o_reg <= DEFAULT_WORD;
      f_reg      <= '0;
      sp_reg     <= '0;
      done_o_reg <= 1'b0;
      h_o_reg    <= 1'b0;
      s_o_reg    <= 1'b0;
    end else begin
      word_o_reg <= word_reg;
      f_reg      <= f;
      sp_reg     <= sp;
      done_o_reg <= done_reg;
      h_o_reg    <= hdrv_reg;
      s_o_reg    <= sdrv_reg;
    end
  end

  // Open-drain: pin only pulled low, never driven high
  always_comb begin
    mem_req_out          = req_reg;
    hard_config_word_out = word_o_reg;
    fields_out           = f_reg;
    straps_out           = sp_reg;
    config_done_out      = done_o_reg;
    hard_reset_n_out     = 1'b0;
    hard_reset_n_oe_out  = h_o_reg;
    soft_reset_n_out     = 1'b0;
    soft_reset_n_oe_out  = s_o_reg;
  end

endmodule
`default_nettype wire

// file: tb/rcwl_loader_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module rcwl_loader_monitor
  import rcwl_pkg::*;
(
  // Clock and pins
  input wire logic                    clk_in,
  input wire logic                    nrst_in,
  input wire logic                    power_on_reset_n_in,
  input wire logic                    reset_config_select_in,
  input wire logic                    host_port_enable_pin_in,
  input wire logic                    debug_select_pin_in,
  input wire logic [1:0]              boot_mode_pins_in,
  input wire logic                    int_hard_src_in,
  // Outputs watched
  input wire rcwl_pkg::rcwl_mem_req_t mem_req_out,
  input wire logic [31:0]             hard_config_word_out,
  input wire rcwl_pkg::rcwl_fields_t  fields_out,
  input wire rcwl_pkg::rcwl_straps_t  straps_out,
  input wire logic                    config_done_out,
  input wire logic                    hard_reset_n_out,
  input wire logic                    hard_reset_n_oe_out,
  input wire logic                    soft_reset_n_out,
  input wire logic                    soft_reset_n_oe_out
);
  logic [9:0] hard_run_reg;
  logic [9:0] hard_run_next;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  // Length of the running hard pull, saturates so it never wraps
  always_comb begin
    hard_run_next = 10'h000;
    if (hard_reset_n_oe_out) begin
      hard_run_next = hard_run_reg + {9'h000, hard_run_reg != 10'h3ff};
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      hard_run_reg <= 10'h000;
    end else begin
      hard_run_reg <= hard_run_next;
    end
  end

  sequence mem_walk_s;
    mem_req_out.read && mem_req_out.addr == BOOT_ADDR1 ##2
    mem_req_out.read && mem_req_out.addr == BOOT_ADDR2 ##2
    mem_req_out.read && mem_req_out.addr == BOOT_ADDR3;
  endsequence

  // Outputs settle a few cycles after done
  sequence settled_s;
    config_done_out [*4];
  endsequence

  mem_order_a: assert property (
    mem_req_out.read && mem_req_out.addr == BOOT_ADDR0 |-> ##2 mem_walk_s)
    else $error("boot read order wrong");
  open_drain_a: assert property (!hard_reset_n_out && !soft_reset_n_out)
    else $error("reset line driven high");
  hard_start_a: assert property ($rose(int_hard_src_in) |-> ##[1:4] hard_reset_n_oe_out)
    else $error("hard stretch not started");
  hard_stretch_a: assert property ($fell(hard_reset_n_oe_out) |-> hard_run_reg == 10'h200)
    else $error("hard stretch too short");
  soft_tail_a: assert property (
    $fell(hard_reset_n_oe_out) |-> soft_reset_n_oe_out [*3] ##1 !soft_reset_n_oe_out)
    else $error("soft tail length wrong");
  soft_cover_a: assert property (
    hard_reset_n_oe_out && $past(hard_reset_n_oe_out) |-> soft_reset_n_oe_out)
    else $error("soft released under hard");
  strap_mode_a: assert property ($rose(power_on_reset_n_in) |-> ##[3:6]
    straps_out.boot_source == boot_mode_pins_in &&
    straps_out.host_port_on == host_port_enable_pin_in)
    else $error("straps not captured");
  debug_pol_a: assert property ($rose(power_on_reset_n_in) |-> ##[3:6]
    straps_out.debug_enable == !debug_select_pin_in)
    else $error("debug polarity wrong");
  default_word_a: assert property (
    $rose(config_done_out) && !reset_config_select_in |-> ##[0:2]
    hard_config_word_out == DEFAULT_WORD)
    else $error("default word not used");
  field_bits_a: assert property (settled_s |->
    fields_out.line_seven_int_out_select == hard_config_word_out[29] &&
    fields_out.bus_mode_select == hard_config_word_out[28] &&
    fields_out.external_memctl_select == hard_config_word_out[30] &&
    fields_out.isp_64 == !hard_config_word_out[24])
    else $error("field bits mismatch word");
  field_decode_a: assert property (settled_s |->
    fields_out.boot_port_32 == (fields_out.boot_port_width == 2'h3) &&
    fields_out.irq_pins_nc == (fields_out.interrupt_pin_config == 2'h0) &&
    fields_out.parity_as_irq == (fields_out.parity_pin_config == 2'h0) &&
    fields_out.nmi_to_core == !fields_out.nmi_route_select &&
    fields_out.tc_as_bank_select == (fields_out.transfer_code_pin_config == 2'h2))
    else $error("field decode wrong");
  space_base_a: assert property (settled_s |->
    fields_out.internal_space_base != 3'h0 || fields_out.internal_space_addr == 32'hf0000000)
    else $error("internal space base wrong");
endmodule
bind rcwl_loader rcwl_loader_monitor u_mon (.*);
`default_nettype wire

// file: tb/rcwl_boot_mem.sv
`timescale 1ns/10ps
`default_nettype none
module rcwl_boot_mem
  import rcwl_pkg::*;
(
  // Clock and request
  input  wire logic                    clk_in,
  input  wire rcwl_pkg::rcwl_mem_req_t req_in,
  input  wire logic [31:0]             image_in,
  // Byte lane
  output logic [7:0]                   data_out
);
  logic [7:0] lane;
  logic [7:0] last_reg = 8'h5a;

  // Flash answers within the read cycle; off a read the lane shows the
  // inverse of its last value so stale data never passes
  always_comb begin
    case (req_in.addr)
      BOOT_ADDR0: lane = image_in[31:24];
      BOOT_ADDR1: lane = image_in[23:16];
      BOOT_ADDR2: lane = image_in[15:8];
      BOOT_ADDR3: lane = image_in[7:0];
      default:    lane = ~last_reg;
    endcase
    if (req_in.read) begin
      data_out = lane;
    end else begin
      data_out = ~last_reg;
    end
  end

  always @(posedge clk_in) begin
    last_reg <= data_out;
  end
endmodule
`default_nettype wire

// file: tb/tb_rcwl_loader.sv
`timescale 1ns/10ps
`default_nettype none
module tb_rcwl_loader;
  import rcwl_pkg::*;
  logic          clk_in, nrst_in, power_on_reset_n_in, hard_reset_n_in;
  logic          reset_config_select_in, host_port_enable_pin_in, debug_select_pin_in;
  logic [1:0]    boot_mode_pins_in;
  logic          int_hard_src_in, int_soft_src_in, host_wr_in, host_half_sel_in;
  logic [15:0]   host_data_in;
  logic [7:0]    mem_data_in;
  rcwl_mem_req_t mem_req_out;
  logic [31:0]   hard_config_word_out, mem_image, exp_word;
  rcwl_fields_t  fields_out;
  rcwl_straps_t  straps_out;
  logic          config_done_out, hard_reset_n_out, hard_reset_n_oe_out;
  logic          soft_reset_n_out, soft_reset_n_oe_out, exp_dll;
  int            mismatches, samples_checked, cycles, seed;

  rcwl_loader u_dut (.*);
  rcwl_boot_mem u_mem (.clk_in(clk_in), .req_in(mem_req_out), .image_in(mem_image),
                       .data_out(mem_data_in));

  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  task automatic check(input logic ok, input string what);
    samples_checked++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("[ERR] %0t %s", $time, what);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic power_on(input logic hp, input logic [1:0] bm, input logic dg);
    power_on_reset_n_in <= 1'b0;
    host_port_enable_pin_in <= hp;
    boot_mode_pins_in <= bm;
    debug_select_pin_in <= dg;
    tick(4);
    power_on_reset_n_in <= 1'b1;
    tick(8);
    check(straps_out === {~dg, bm, hp}, "straps");
  endtask

  task automatic pulse_hard(input logic sel);
    reset_config_select_in <= sel;
    tick(1);
    hard_reset_n_in <= 1'b0;
    tick(4);
    hard_reset_n_in <= 1'b1;
    tick(1);
  endtask

  // Waits for done, then compares against the bench model
  task automatic finish_load(input logic first);
    int n;
    n = 0;
    while (config_done_out !== 1'b1 && n < 200) begin
      tick(1);
      n++;
    end
    tick(4);
    if (first) exp_dll = exp_word[4];
    check(n < 200, "load hung");
    check(hard_config_word_out === exp_word, "word");
    check(fields_out.delay_loop_disable === exp_dll, "dll");
    check(fields_out.clock_mode_high_bits === exp_word[3:1], "modck");
    check(fields_out.bus_busy_pin_select === exp_word[14], "busy pins");
    check(fields_out.external_arbitration_select === exp_word[31], "arb");
    check(fields_out.line_seven_int_out_select === exp_word[29], "line7");
  endtask

  task automatic host_write(input logic s, input logic [15:0] d);
    host_half_sel_in <= s;
    host_data_in <= d;
    host_wr_in <= 1'b1;
    tick(1);
    host_wr_in <= 1'b0;
    tick(1);
  endtask

  task automatic stretch(input logic hard);
    int nh;
    int ns;
    nh = 0;
    ns = 0;
    int_hard_src_in <= hard;
    int_soft_src_in <= ~hard;
    tick(1);
    int_hard_src_in <= 1'b0;
    int_soft_src_in <= 1'b0;
    repeat (560) begin
      tick(1);
      nh += int'(hard_reset_n_oe_out === 1'b1);
      ns += int'(soft_reset_n_oe_out === 1'b1);
    end
    if (hard) check(nh >= 512 && nh <= 516 && ns >= nh + 2 && ns <= nh + 5, "hard");
    else check(nh == 0 && ns >= 512 && ns <= 516, "soft");
  endtask

  always @(posedge clk_in) begin
    cycles++;
    if (cycles > 6000) begin
      mismatches++;
      $display("[ERR] %0t timeout", $time);
      report_and_stop();
    end
  end

  initial begin
    seed = 32'h1cf2;
    nrst_in = 1'b0;
    power_on_reset_n_in = 1'b0;
    hard_reset_n_in = 1'b1;
    {reset_config_select_in, host_port_enable_pin_in, debug_select_pin_in} = 3'h0;
    boot_mode_pins_in = 2'h0;
    {int_hard_src_in, int_soft_src_in, host_wr_in, host_half_sel_in} = 4'h0;
    host_data_in = 16'h0000;
    mem_image = 32'h00000000;
    exp_dll = 1'b0;
    tick(4);
    nrst_in <= 1'b1;
    for (int m = 0; m < 4; m++) power_on(1'b0, 2'(m), m[0]);
    pulse_hard(1'b0);
    exp_word = {8'h2c, 8'h00, 8'h02, 8'h1e};
    finish_load(1'b1);
    // Later loads must not move the delay-loop bit
    repeat (2) begin
      mem_image = $random(seed);
      mem_image[4] = ~exp_dll;
      exp_word = mem_image;
      pulse_hard(1'b1);
      finish_load(1'b0);
    end
    power_on(1'b1, 2'($random(seed)), 1'($random(seed)));
    exp_word = $random(seed);
    host_write(1'b0, ~exp_word[31:16]);
    pulse_hard(1'b1);
    host_write(1'b1, ~exp_word[15:0]);
    host_write(1'b1, exp_word[15:0]);
    host_write(1'b0, exp_word[31:16]);
    finish_load(1'b1);
    stretch(1'b0);
    stretch(1'b1);
    report_and_stop();
  end
endmodule
`default_nettype wire
